//--- rsr_pkg.sv
// shared constants and carriers for the reset and stop recovery control
package rsr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int RSR_CLK_MHZ = 250;
    // reset pin must be seen low this many clocks (async edge may cost one)
    localparam int RSR_PIN_MIN_CLKS = 3;
    localparam logic [2:0] RSR_PIN_MIN_CNT = 3'(RSR_PIN_MIN_CLKS);
    // length of the internal system reset sequence, in clocks
    localparam int RSR_SEQ_CLKS = 16;
    localparam logic [4:0] RSR_SEQ_CNT = 5'(RSR_SEQ_CLKS);
    // length of the sleep exit sequence, in clocks
    localparam int RSR_EXIT_CLKS = 8;
    localparam logic [4:0] RSR_EXIT_CNT = 5'(RSR_EXIT_CLKS);

    // ------------------------------------------------------------
    // reset cause register layout
    // ------------------------------------------------------------
    localparam int RSR_CAUSE_W = 5;
    localparam int RSR_BIT_POR = 0;
    localparam int RSR_BIT_PIN = 1;
    localparam int RSR_BIT_WDOG = 2;
    localparam int RSR_BIT_STOP = 3;
    localparam int RSR_BIT_DBG = 4;
    localparam logic [4:0] RSR_CAUSE_RST = 5'h01;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic watchdog_timeout;
        logic watchdog_response_select_option;
        logic int_enable;
        logic stop_mode;
        logic supply_brownout_detect;
    } rsr_ctl_t;

    typedef enum logic [3:0] {
        RSR_ST_RUN = 4'h1,
        RSR_ST_RESET = 4'h2,
        RSR_ST_EXIT = 4'h4,
        RSR_ST_BROWN = 4'h8
    } rsr_state_t;

endpackage : rsr_pkg

//--- rsr_sync.sv
// two-flop synchroniser with one-cycle delayed copy for edge detection
`timescale 1ns/1ns
module rsr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out,
    output logic [W-1:0] sync_d_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;
    logic [W-1:0] last_r;
    logic [W-1:0] last_nxt;

    always_comb
    begin
        meta_nxt = meta_r;
        sync_nxt = sync_r;
        last_nxt = last_r;
        if (clk_en_in)
        begin
            meta_nxt = async_in;
            sync_nxt = meta_r;
            last_nxt = sync_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
            last_r <= INIT;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
        end
    end

    assign sync_out = sync_r;
    assign sync_d_out = last_r;
endmodule : rsr_sync

//--- rsr_ctrl.sv
// reset source and stop mode recovery control
// What this block does
// - outside stop mode a watchdog time-out with the option at 1 gives a system reset.
// - with the option at 0 a watchdog time-out raises an interrupt request instead.
// - a reset started by the watchdog sets the watchdog cause flag.
// - a reset pin held low for four clocks always leads to the system reset sequence.
// - a reset pin seen low for three synchronised clocks is already accepted.
// - every completed sleep exit sequence sets the stop flag.
// - in stop mode a watchdog reset response gives a sleep exit, not a reset.
// - in stop mode a watchdog interrupt response exits, then interrupts if enabled.
// - in stop mode a change on a wake-enabled pin starts a sleep exit.
// - in stop mode the reset pin gives a full system reset.
// - in stop mode a low debug pin gives a full system reset.
// - after brown-out the block runs a full power-on reset sequence.
// - a watchdog wake from stop sets both the watchdog and stop flags.
// - wake pins act on either edge.
`timescale 1ns/1ns
module rsr_ctrl #(
    parameter int WAKE_W = 8
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // pins
    input wire logic ext_reset_n_in,
    input wire logic debug_pin_in,
    input wire logic [WAKE_W-1:0] wake_pin_in,
    input wire logic [WAKE_W-1:0] wake_enable_in,
    // control from the core
    input wire rsr_pkg::rsr_ctl_t ctl_in,
    // results
    output logic sys_reset_out,
    output logic exit_busy_out,
    output logic exit_done_out,
    output logic wdog_irq_out,
    output logic [rsr_pkg::RSR_CAUSE_W-1:0] reset_cause_register_out
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    localparam int SW = WAKE_W + 2;
    logic [SW-1:0] pin_s;
    logic [SW-1:0] pin_d;

    rsr_sync #(
        .W(SW),
        .INIT({SW{1'b1}})
    ) u_sync (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .async_in({ext_reset_n_in, debug_pin_in, wake_pin_in}),
        .sync_out(pin_s),
        .sync_d_out(pin_d)
    );

    logic rst_pin_low;
    logic dbg_low;
    logic wake_edge;
    assign rst_pin_low = !pin_s[SW-1];
    assign dbg_low = !pin_s[SW-2];
    // either direction counts, only on enabled pins
    assign wake_edge = |((pin_s[WAKE_W-1:0] ^ pin_d[WAKE_W-1:0])
        & wake_enable_in);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    rsr_pkg::rsr_state_t st_r;
    rsr_pkg::rsr_state_t st_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [2:0] pin_cnt_r;
    logic [2:0] pin_cnt_nxt;
    logic [4:0] cause_r;
    logic [4:0] cause_nxt;
    logic irq_r;
    logic irq_nxt;
    logic irq_pend_r;
    logic irq_pend_nxt;
    logic done_r;
    logic done_nxt;
    logic pin_ok;
    logic wdog_rst;

    // a pin low for three synchronised clocks is taken as a real reset;
    // the first clock may be lost to the asynchronous edge
    assign pin_ok = rst_pin_low
        && (pin_cnt_r >= rsr_pkg::RSR_PIN_MIN_CNT - 3'h1);
    assign wdog_rst = ctl_in.watchdog_timeout
        && ctl_in.watchdog_response_select_option;

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pin_cnt_nxt = pin_cnt_r;
        cause_nxt = cause_r;
        irq_nxt = irq_r;
        irq_pend_nxt = irq_pend_r;
        done_nxt = done_r;
        if (clk_en_in)
        begin
            // pulses last one enabled cycle, so they freeze with the rest
            irq_nxt = 1'b0;
            done_nxt = 1'b0;
            pin_cnt_nxt = rst_pin_low
                ? (pin_cnt_r == 3'h7 ? pin_cnt_r : pin_cnt_r + 3'h1)
                : 3'h0;
            if (ctl_in.supply_brownout_detect)
            begin
                st_nxt = rsr_pkg::RSR_ST_BROWN;
                cnt_nxt = 5'h00;
                cause_nxt = rsr_pkg::RSR_CAUSE_RST;
                irq_pend_nxt = 1'b0;
            end
            else
            begin
                case (st_r)
                    rsr_pkg::RSR_ST_RUN:
                    begin
                        if (pin_ok)
                        begin
                            st_nxt = rsr_pkg::RSR_ST_RESET;
                            cnt_nxt = 5'h00;
                            cause_nxt = 5'h00;
                            cause_nxt[rsr_pkg::RSR_BIT_PIN] = 1'b1;
                        end
                        else if (ctl_in.stop_mode && dbg_low)
                        begin
                            st_nxt = rsr_pkg::RSR_ST_RESET;
                            cnt_nxt = 5'h00;
                            cause_nxt = 5'h00;
                            cause_nxt[rsr_pkg::RSR_BIT_DBG] = 1'b1;
                        end
                        else if (ctl_in.stop_mode
                            && (ctl_in.watchdog_timeout || wake_edge))
                        begin
                            st_nxt = rsr_pkg::RSR_ST_EXIT;
                            cnt_nxt = 5'h00;
                            cause_nxt = 5'h00;
                            cause_nxt[rsr_pkg::RSR_BIT_WDOG] =
                                ctl_in.watchdog_timeout;
                            irq_pend_nxt = ctl_in.watchdog_timeout
                                && !ctl_in.watchdog_response_select_option
                                && ctl_in.int_enable;
                        end
                        else if (wdog_rst)
                        begin
                            st_nxt = rsr_pkg::RSR_ST_RESET;
                            cnt_nxt = 5'h00;
                            cause_nxt = 5'h00;
                            cause_nxt[rsr_pkg::RSR_BIT_WDOG] = 1'b1;
                        end
                        else if (ctl_in.watchdog_timeout)
                        begin
                            irq_nxt = 1'b1;
                        end
                    end
                    rsr_pkg::RSR_ST_EXIT:
                    begin
                        if (pin_ok)
                        begin
                            st_nxt = rsr_pkg::RSR_ST_RESET;
                            cnt_nxt = 5'h00;
                            cause_nxt = 5'h00;
                            cause_nxt[rsr_pkg::RSR_BIT_PIN] = 1'b1;
                            irq_pend_nxt = 1'b0;
                        end
                        else if (cnt_r == rsr_pkg::RSR_EXIT_CNT - 5'h01)
                        begin
                            st_nxt = rsr_pkg::RSR_ST_RUN;
                            cause_nxt[rsr_pkg::RSR_BIT_STOP] = 1'b1;
                            done_nxt = 1'b1;
                            irq_nxt = irq_pend_r;
                            irq_pend_nxt = 1'b0;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + 5'h01;
                        end
                    end
                    rsr_pkg::RSR_ST_RESET,
                    rsr_pkg::RSR_ST_BROWN:
                    begin
                        // the pin held low keeps the sequence from ending
                        if (rst_pin_low)
                        begin
                            cnt_nxt = 5'h00;
                        end
                        else if (cnt_r == rsr_pkg::RSR_SEQ_CNT - 5'h01)
                        begin
                            st_nxt = rsr_pkg::RSR_ST_RUN;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + 5'h01;
                        end
                    end
                    default:
                    begin
                        st_nxt = rsr_pkg::RSR_ST_BROWN;
                        cnt_nxt = 5'h00;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_r <= rsr_pkg::RSR_ST_BROWN;
            cnt_r <= 5'h00;
            pin_cnt_r <= 3'h0;
            cause_r <= rsr_pkg::RSR_CAUSE_RST;
            irq_r <= 1'b0;
            irq_pend_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pin_cnt_r <= pin_cnt_nxt;
            cause_r <= cause_nxt;
            irq_r <= irq_nxt;
            irq_pend_r <= irq_pend_nxt;
            done_r <= done_nxt;
        end
    end

    assign sys_reset_out = (st_r == rsr_pkg::RSR_ST_RESET)
        || (st_r == rsr_pkg::RSR_ST_BROWN);
    assign exit_busy_out = (st_r == rsr_pkg::RSR_ST_EXIT);
    assign exit_done_out = done_r;
    assign wdog_irq_out = irq_r;
    assign reset_cause_register_out = cause_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_stop_wdog;
        clk_en_in && st_r == rsr_pkg::RSR_ST_RUN && ctl_in.stop_mode
        && ctl_in.watchdog_timeout && !pin_ok && !dbg_low
        && !ctl_in.supply_brownout_detect;
    endsequence

    property p_wdog_reset;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (clk_en_in && st_r == rsr_pkg::RSR_ST_RUN && !ctl_in.stop_mode
        && wdog_rst && !pin_ok && !ctl_in.supply_brownout_detect)
        |=> sys_reset_out && cause_r[rsr_pkg::RSR_BIT_WDOG];
    endproperty
    a_wdog_reset: assert property (p_wdog_reset)
        else $error("watchdog did not reset");

    property p_wdog_irq;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (clk_en_in && st_r == rsr_pkg::RSR_ST_RUN && !ctl_in.stop_mode
        && ctl_in.watchdog_timeout
        && !ctl_in.watchdog_response_select_option && !pin_ok
        && !ctl_in.supply_brownout_detect)
        |=> wdog_irq_out && !sys_reset_out;
    endproperty
    a_wdog_irq: assert property (p_wdog_irq)
        else $error("watchdog interrupt missing");

    property p_stop_wdog;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_stop_wdog |=> exit_busy_out && !sys_reset_out
        && cause_r[rsr_pkg::RSR_BIT_WDOG];
    endproperty
    a_stop_wdog: assert property (p_stop_wdog)
        else $error("stop watchdog did not start exit");

    property p_exit_flag;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(exit_done_out) |-> cause_r[rsr_pkg::RSR_BIT_STOP]
        && $past(exit_busy_out);
    endproperty
    a_exit_flag: assert property (p_exit_flag)
        else $error("stop flag not set on exit");

    property p_pin_reset;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (clk_en_in && pin_ok && !ctl_in.supply_brownout_detect
        && (st_r == rsr_pkg::RSR_ST_RUN || st_r == rsr_pkg::RSR_ST_EXIT))
        |=> sys_reset_out && cause_r[rsr_pkg::RSR_BIT_PIN];
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin ignored");

    property p_short_pin;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (clk_en_in && rst_pin_low && pin_cnt_r == 3'h0
        && st_r == rsr_pkg::RSR_ST_RUN && !ctl_in.watchdog_timeout
        && !(ctl_in.stop_mode && dbg_low)
        && !ctl_in.supply_brownout_detect) |=> !sys_reset_out;
    endproperty
    a_short_pin: assert property (p_short_pin)
        else $error("single low sample accepted");

    property p_brown;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (clk_en_in && ctl_in.supply_brownout_detect)
        |=> st_r == rsr_pkg::RSR_ST_BROWN
        && cause_r == rsr_pkg::RSR_CAUSE_RST;
    endproperty
    a_brown: assert property (p_brown)
        else $error("brown-out did not force power-on reset");

    property p_wake;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (clk_en_in && st_r == rsr_pkg::RSR_ST_RUN && ctl_in.stop_mode
        && wake_edge && !pin_ok && !dbg_low
        && !ctl_in.supply_brownout_detect) |=> exit_busy_out;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake edge missed");
endmodule : rsr_ctrl

//--- rsr_pin_model.sv
// behavioural model of the reset pin, debug pin and wake pins
`timescale 1ns/1ns
module rsr_pin_model #(
    parameter int WAKE_W = 8
) (
    // clock
    input wire logic core_clk_in,
    // pins
    output logic ext_reset_n_out,
    output logic debug_pin_out,
    output logic [WAKE_W-1:0] wake_pin_out
);
    // reset and debug pins carry pull-ups, so released means high
    initial
    begin
        ext_reset_n_out = 1'b1;
        debug_pin_out = 1'b1;
        wake_pin_out = '1;
    end

    // low for n whole clocks; n below three only probes the short margin
    task automatic hold_reset(input int n);
        @(posedge core_clk_in);
        #1;
        ext_reset_n_out = 1'b0;
        repeat (n) @(posedge core_clk_in);
        #1;
        ext_reset_n_out = 1'b1;
    endtask : hold_reset

    task automatic debug_low(input int n);
        @(posedge core_clk_in);
        #1;
        debug_pin_out = 1'b0;
        repeat (n) @(posedge core_clk_in);
        #1;
        debug_pin_out = 1'b1;
    endtask : debug_low

    task automatic flip_wake(input int i);
        @(posedge core_clk_in);
        #1;
        wake_pin_out[i] = ~wake_pin_out[i];
    endtask : flip_wake
endmodule : rsr_pin_model

//--- test_reset_and_stop_recovery_control.sv
// self-checking bench for the reset and stop recovery control
`timescale 1ns/1ns
`define CHK(a, b) check_val(32'(a), 32'(b))
module test_reset_and_stop_recovery_control;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    rsr_pkg::rsr_ctl_t ctl = 5'h08;
    logic [7:0] wake_en = 8'h00;
    wire logic ext_reset_n;
    wire logic debug_pin;
    wire logic [7:0] wake_pin;
    logic sys_reset, exit_busy, exit_done, wdog_irq;
    logic [4:0] cause;
    int err_count = 0;
    int n_checks = 0;
    localparam logic [4:0] PIN = 5'h01 << rsr_pkg::RSR_BIT_PIN;
    localparam logic [4:0] WD = 5'h01 << rsr_pkg::RSR_BIT_WDOG;
    localparam logic [4:0] STP = 5'h01 << rsr_pkg::RSR_BIT_STOP;
    localparam logic [4:0] DBG = 5'h01 << rsr_pkg::RSR_BIT_DBG;

    rsr_ctrl #(.WAKE_W(8)) dut (
        .core_clk_in(core_clk), .reset_n_in(reset_n), .clk_en_in(clk_en),
        .ext_reset_n_in(ext_reset_n), .debug_pin_in(debug_pin),
        .wake_pin_in(wake_pin), .wake_enable_in(wake_en), .ctl_in(ctl),
        .sys_reset_out(sys_reset), .exit_busy_out(exit_busy),
        .exit_done_out(exit_done), .wdog_irq_out(wdog_irq),
        .reset_cause_register_out(cause)
    );
    rsr_pin_model #(.WAKE_W(8)) pins (
        .core_clk_in(core_clk), .ext_reset_n_out(ext_reset_n),
        .debug_pin_out(debug_pin), .wake_pin_out(wake_pin)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : check_val

    function automatic logic sel(input int k);
        case (k)
            0: return sys_reset;
            1: return exit_busy;
            2: return exit_done;
            default: return wdog_irq;
        endcase
    endfunction : sel

    // bounded wait; running out is a mismatch and ends the run
    task automatic wait_for(input int k, input logic v, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            if (sel(k) === v)
                return;
            @(posedge core_clk);
            #1;
        end
        err_count++;
        $display("unexpected at %0t: got %h exp %h", $time, sel(k), v);
        give_verdict();
    endtask : wait_for

    task automatic wd_pulse();
        @(posedge core_clk);
        #1;
        ctl.watchdog_timeout = 1'b1;
        @(posedge core_clk);
        #1;
        ctl.watchdog_timeout = 1'b0;
    endtask : wd_pulse

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_on();
        wait_for(0, 1'b0, 40);
        `CHK(cause, 5'h01);
        @(posedge core_clk);
        #1;
        ctl.supply_brownout_detect = 1'b1;
        @(posedge core_clk);
        #1;
        ctl.supply_brownout_detect = 1'b0;
        `CHK(sys_reset, 1'b1);
        wait_for(0, 1'b0, 40);
        `CHK(cause, 5'h01);
    endtask : t_power_on

    task automatic t_wdog_run();
        wd_pulse();
        `CHK(sys_reset, 1'b1);
        `CHK(cause, WD);
        wait_for(0, 1'b0, 40);
        ctl.watchdog_response_select_option = 1'b0;
        wd_pulse();
        `CHK(wdog_irq, 1'b1);
        `CHK(sys_reset, 1'b0);
        ctl.watchdog_response_select_option = 1'b1;
    endtask : t_wdog_run

    // enable low must freeze a running reset sequence and drop requests
    task automatic t_freeze();
        wd_pulse();
        clk_en = 1'b0;
        repeat (30) @(posedge core_clk);
        #1;
        `CHK(sys_reset, 1'b1);
        clk_en = 1'b1;
        wait_for(0, 1'b0, 40);
        `CHK(cause, WD);
        clk_en = 1'b0;
        wd_pulse();
        repeat (2) @(posedge core_clk);
        #1;
        clk_en = 1'b1;
        @(posedge core_clk);
        #1;
        `CHK(sys_reset, 1'b0);
    endtask : t_freeze

    task automatic t_pin(input int n);
        pins.hold_reset(n);
        wait_for(0, 1'b1, 8);
        `CHK(cause, PIN);
        wait_for(0, 1'b0, 40);
    endtask : t_pin

    task automatic t_stop_wdog(input logic opt, input logic ie);
        ctl.stop_mode = 1'b1;
        ctl.watchdog_response_select_option = opt;
        ctl.int_enable = ie;
        wd_pulse();
        `CHK(sys_reset, 1'b0);
        `CHK(exit_busy, 1'b1);
        wait_for(2, 1'b1, 12);
        `CHK(wdog_irq, !opt && ie);
        `CHK(cause, WD | STP);
        ctl = 5'h08;
    endtask : t_stop_wdog

    task automatic t_stop_wake();
        ctl.stop_mode = 1'b1;
        wake_en = 8'h04;
        pins.flip_wake(5);
        repeat (6) @(posedge core_clk);
        #1;
        `CHK(exit_busy, 1'b0);
        for (int d = 0; d < 2; d++)
        begin
            pins.flip_wake(2);
            wait_for(1, 1'b1, 8);
            `CHK(exit_busy, 1'b1);
            wait_for(2, 1'b1, 12);
            `CHK(cause[rsr_pkg::RSR_BIT_STOP], 1'b1);
        end
        wake_en = 8'h00;
        ctl = 5'h08;
    endtask : t_stop_wake

    task automatic t_stop_pins();
        ctl.stop_mode = 1'b1;
        pins.hold_reset(4);
        wait_for(0, 1'b1, 8);
        `CHK(exit_busy, 1'b0);
        `CHK(cause, PIN);
        wait_for(0, 1'b0, 40);
        pins.debug_low(4);
        wait_for(0, 1'b1, 8);
        `CHK(cause, DBG);
        wait_for(0, 1'b0, 40);
        ctl = 5'h08;
    endtask : t_stop_pins

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (4) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        t_power_on();
        t_wdog_run();
        t_freeze();
        t_pin(4);
        t_pin(3);
        t_stop_wdog(1'b1, 1'b0);
        t_stop_wdog(1'b0, 1'b1);
        t_stop_wdog(1'b0, 1'b0);
        t_stop_wake();
        t_stop_pins();
        give_verdict();
    end
endmodule : test_reset_and_stop_recovery_control
